// *** pds_pkg.sv ***
// Constants and carrier types for the PHY data service port
package pds_pkg;
  // Time base
  localparam int TIMER_W  = 20;
  localparam int CLK_MHZ  = 250;
  localparam int TICK_US  = 10;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int PRE_W    = 12;
  localparam logic [PRE_W-1:0]   PRE_LAST  = PRE_W'(TICK_CYC - 1);
  localparam logic [TIMER_W-1:0] TIMER_MAX = 20'hfffff;
  // A start time further ahead than this is taken as already past
  localparam logic [TIMER_W-1:0] LATE_LIMIT = 20'h7ffff;
  // Field widths
  localparam int LEN_W  = 16;
  localparam int LVL_W  = 3;
  localparam int RLVL_W = 4;
  localparam int SCH_W  = 3;
  localparam int RES_W  = 8;
  // Byte buffers
  localparam int BUF_AW    = 11;
  localparam int BUF_DEPTH = 2048;
  localparam logic [LEN_W-1:0] BUF_LEN_MAX = 16'h0800;
  // Scheme codes that carry no modulation
  localparam logic [SCH_W-1:0] SCH_NONE_A = 3'h3;
  localparam logic [SCH_W-1:0] SCH_NONE_B = 3'h7;
  // Confirmation result codes
  localparam logic [RES_W-1:0] RES_OK      = 8'h00;
  localparam logic [RES_W-1:0] RES_LATE    = 8'h01;
  localparam logic [RES_W-1:0] RES_BAD_LEN = 8'h02;
  localparam logic [RES_W-1:0] RES_BAD_SCH = 8'h03;
  localparam logic [RES_W-1:0] RES_BAD_LVL = 8'h04;
  localparam logic [RES_W-1:0] RES_OVERRUN = 8'h05;
  localparam logic [RES_W-1:0] RES_BUSY    = 8'h06;
  localparam logic [RES_W-1:0] RES_FORBID  = 8'h07;
  // Register byte offsets
  localparam logic [7:0] OFF_TIMER    = 8'h00;
  localparam logic [7:0] OFF_TX_LEN   = 8'h04;
  localparam logic [7:0] OFF_TX_PARAM = 8'h08;
  localparam logic [7:0] OFF_TX_TIME  = 8'h0c;
  localparam logic [7:0] OFF_TX_DATA  = 8'h10;
  localparam logic [7:0] OFF_TX_CMD   = 8'h14;
  localparam logic [7:0] OFF_TX_STAT  = 8'h18;
  localparam logic [7:0] OFF_FB_START = 8'h1c;
  localparam logic [7:0] OFF_FB_END   = 8'h20;
  localparam logic [7:0] OFF_FB_CTRL  = 8'h24;
  localparam logic [7:0] OFF_RX_STAT  = 8'h28;
  localparam logic [7:0] OFF_RX_TIME  = 8'h2c;
  localparam logic [7:0] OFF_RX_DATA  = 8'h30;
  // Field positions
  localparam int TXP_LVL_LSB = 0;
  localparam int TXP_SCH_LSB = 4;
  localparam int CMD_GO      = 0;
  localparam int FB_EN       = 0;
  localparam int TXS_PEND    = 0;
  localparam int TXS_DONE    = 1;
  localparam int TXS_RES_LSB = 8;
  localparam int RXS_AVAIL   = 0;
  localparam int RXS_LVL_LSB = 4;
  localparam int RXS_SCH_LSB = 8;
  localparam int RXS_LEN_LSB = 16;
  // Carriers
  typedef struct packed {
    logic [LEN_W-1:0]   len;
    logic [LVL_W-1:0]   level;
    logic [SCH_W-1:0]   scheme;
    logic [TIMER_W-1:0] start;
  } pds_tx_req_type;
  typedef struct packed {
    logic [RLVL_W-1:0] level;
    logic [SCH_W-1:0]  scheme;
  } pds_rx_info_type;
endpackage : pds_pkg

// *** pds_mem.sv ***
// Byte buffer with one write port and a registered read port
`timescale 1ns/10ps
module pds_mem (
  input  wire logic                       i_clk,
  input  wire logic                       i_we,
  input  wire logic [pds_pkg::BUF_AW-1:0] i_waddr,
  input  wire logic [7:0]                 i_wdata,
  input  wire logic [pds_pkg::BUF_AW-1:0] i_raddr,
  output logic      [7:0]                 o_rdata
);
  logic [7:0] mem [pds_pkg::BUF_DEPTH];

  // Contents are not reset; a byte read before any write to it returns an undefined value
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule : pds_mem

// *** pds_port.sv ***
// PHY data service port: time base, transmit requests, receive indications
//
// Overview of operation
// - One free-running 20-bit counter advancing every 10 microseconds.
// - Counter runs 0 to 1048575 then wraps to zero.
// - Counter is never halted or reloaded by any request.
// - Requests only flow in from MAC; confirms and indications only out.
// - Data units are byte aligned; first byte holds 2 leading pad bits.
// - Transmit length is a 2-byte count of bytes.
// - Level code 0 is maximum output, each step 3 dB lower.
// - Schemes 0-2 plain, 4-6 coded, 3 and 7 unused; same on receive.
// - Start time is in 10 microsecond ticks over the full counter.
// - Transmission begins when counter equals requested start time.
// - A start inside a forbidden period yields a failure confirm.
// - Every transmit request gets one confirmation of its outcome; a go written while one is pending is ignored and gets none.
// - Result codes 0 ok through 6 busy; 7 and up vendor defined.
// - Receive indication only for a valid frame.
// - Receive length is a 2-byte count of bytes.
// - Receive level is a 4-bit code, 2 dB steps from 70 dBuV.
// - Receive time is the counter value at preamble arrival.
// - A timer read returns the current counter value.
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/10ps
module pds_port (
  input  wire logic                           i_clk,
  input  wire logic                           i_srst,
  input  wire logic                           i_psel,
  input  wire logic                           i_penable,
  input  wire logic                           i_pwrite,
  input  wire logic [7:0]                     i_paddr,
  input  wire logic [31:0]                    i_pwdata,
  output logic      [31:0]                    o_prdata,
  output logic                                o_pready,
  output logic                                o_pslverr,
  output logic                                o_tx_start,
  output pds_pkg::pds_tx_req_type             o_tx_req,
  output logic      [7:0]                     o_tx_byte,
  output logic                                o_tx_valid,
  output logic                                o_tx_last,
  input  wire logic                           i_tx_ready,
  input  wire logic                           i_carrier_busy,
  input  wire logic                           i_rx_preamble,
  input  wire logic [7:0]                     i_rx_byte,
  input  wire logic                           i_rx_byte_valid,
  input  wire logic                           i_rx_frame_ok,
  input  wire logic                           i_rx_frame_bad,
  input  wire pds_pkg::pds_rx_info_type       i_rx_info
);
  typedef enum logic [2:0] {
    TX_IDLE, TX_WAIT, TX_FETCH, TX_LOAD, TX_OUT
  } pds_tx_state_type;

  logic [pds_pkg::PRE_W-1:0]   pre_r;
  logic [pds_pkg::TIMER_W-1:0] timer_r;
  logic                        tick;
  logic                        acc;
  logic                        pready_r;
  logic [31:0]                 rd_val;
  logic                        rd_err;
  pds_pkg::pds_tx_req_type     tx_req_r;
  pds_tx_state_type            state_r;
  logic [pds_pkg::LEN_W-1:0]   tx_wr_ptr_r;
  logic [pds_pkg::LEN_W-1:0]   tx_rd_ptr_r;
  logic [7:0]                  tx_rdata;
  logic                        go;
  logic                        match;
  logic                        busy;
  logic                        last;
  logic [pds_pkg::RES_W-1:0]   chk_res;
  logic                        fin;
  logic [pds_pkg::RES_W-1:0]   fin_res;
  logic                        done_r;
  logic [pds_pkg::RES_W-1:0]   res_r;
  logic [pds_pkg::TIMER_W-1:0] fb_start_r;
  logic [pds_pkg::TIMER_W-1:0] fb_end_r;
  logic                        fb_en_r;
  logic                        rx_active_r;
  logic                        rx_pend_r;
  logic                        rx_set;
  logic [pds_pkg::LEN_W-1:0]   rx_cnt_r;
  logic [pds_pkg::LEN_W-1:0]   rx_len_r;
  logic [pds_pkg::LEN_W-1:0]   rx_rd_ptr_r;
  logic [pds_pkg::TIMER_W-1:0] rx_time_r;
  pds_pkg::pds_rx_info_type    rx_info_r;
  logic [7:0]                  rx_rdata;
  logic                        rx_we;

  // Write hit on one register at the completing access edge
  function automatic logic wr_hit(input logic [7:0] off);
    return acc && i_pwrite && (i_paddr == off);
  endfunction : wr_hit

  // Distance forward from ref to t on the wrapping time base
  function automatic logic [pds_pkg::TIMER_W-1:0] ahead(
    input logic [pds_pkg::TIMER_W-1:0] t,
    input logic [pds_pkg::TIMER_W-1:0] ref_t);
    return t - ref_t;
  endfunction : ahead

  function automatic logic scheme_ok(input logic [pds_pkg::SCH_W-1:0] s);
    return (s != pds_pkg::SCH_NONE_A) && (s != pds_pkg::SCH_NONE_B);
  endfunction : scheme_ok

  //////////////////////////////////////////////////////////////////////////
  // Time base

  // Prescaler makes a one-cycle tick every 10 us
  always_ff @(posedge i_clk) begin
    if (i_srst || tick) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 1'b1;
    end
  end
  assign tick = (pre_r == pds_pkg::PRE_LAST);

  // No load path exists, so only reset can stop or preset the count
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      timer_r <= '0;
    end else if (tick) begin
      timer_r <= timer_r + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // APB slave: every access phase takes two cycles

  assign acc = i_psel & i_penable & pready_r;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pready_r  <= 1'b0;
      o_prdata  <= '0;
      o_pslverr <= 1'b0;
    end else begin
      pready_r  <= i_psel & i_penable & ~pready_r;
      o_prdata  <= i_pwrite ? '0 : rd_val;
      o_pslverr <= rd_err;
    end
  end
  assign o_pready = pready_r;

  // Read mux; unmapped offsets answer with an error
  always_comb begin
    rd_val = '0;
    rd_err = 1'b0;
    case (i_paddr)
      pds_pkg::OFF_TIMER:    rd_val[pds_pkg::TIMER_W-1:0] = timer_r;
      pds_pkg::OFF_TX_LEN:   rd_val[pds_pkg::LEN_W-1:0] = tx_req_r.len;
      pds_pkg::OFF_TX_PARAM: begin
        rd_val[pds_pkg::TXP_LVL_LSB +: pds_pkg::LVL_W] = tx_req_r.level;
        rd_val[pds_pkg::TXP_SCH_LSB +: pds_pkg::SCH_W] = tx_req_r.scheme;
      end
      pds_pkg::OFF_TX_TIME:  rd_val[pds_pkg::TIMER_W-1:0] = tx_req_r.start;
      pds_pkg::OFF_TX_DATA,
      pds_pkg::OFF_TX_CMD:   rd_val = '0;
      pds_pkg::OFF_TX_STAT: begin
        rd_val[pds_pkg::TXS_PEND] = (state_r != TX_IDLE);
        rd_val[pds_pkg::TXS_DONE] = done_r;
        rd_val[pds_pkg::TXS_RES_LSB +: pds_pkg::RES_W] = res_r;
      end
      pds_pkg::OFF_FB_START: rd_val[pds_pkg::TIMER_W-1:0] = fb_start_r;
      pds_pkg::OFF_FB_END:   rd_val[pds_pkg::TIMER_W-1:0] = fb_end_r;
      pds_pkg::OFF_FB_CTRL:  rd_val[pds_pkg::FB_EN] = fb_en_r;
      pds_pkg::OFF_RX_STAT: begin
        rd_val[pds_pkg::RXS_AVAIL] = rx_pend_r;
        rd_val[pds_pkg::RXS_LVL_LSB +: pds_pkg::RLVL_W] = rx_info_r.level;
        rd_val[pds_pkg::RXS_SCH_LSB +: pds_pkg::SCH_W] = rx_info_r.scheme;
        rd_val[pds_pkg::RXS_LEN_LSB +: pds_pkg::LEN_W] = rx_len_r;
      end
      pds_pkg::OFF_RX_TIME:  rd_val[pds_pkg::TIMER_W-1:0] = rx_time_r;
      pds_pkg::OFF_RX_DATA:  rd_val[7:0] = rx_rdata;
      default:               rd_err = 1'b1;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Transmit request registers

  // Fields freeze while a request is pending so its confirm stays its own
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tx_req_r    <= '0;
      tx_wr_ptr_r <= '0;
    end else if (state_r == TX_IDLE) begin
      if (wr_hit(pds_pkg::OFF_TX_LEN)) begin
        tx_req_r.len <= i_pwdata[pds_pkg::LEN_W-1:0];
        tx_wr_ptr_r  <= '0;
      end
      if (wr_hit(pds_pkg::OFF_TX_PARAM)) begin
        tx_req_r.level  <= i_pwdata[pds_pkg::TXP_LVL_LSB +: pds_pkg::LVL_W];
        tx_req_r.scheme <= i_pwdata[pds_pkg::TXP_SCH_LSB +: pds_pkg::SCH_W];
      end
      if (wr_hit(pds_pkg::OFF_TX_TIME)) begin
        tx_req_r.start <= i_pwdata[pds_pkg::TIMER_W-1:0];
      end
      if (wr_hit(pds_pkg::OFF_TX_DATA)) begin
        tx_wr_ptr_r <= tx_wr_ptr_r + 1'b1;
      end
    end
  end

  // Forbidden window, kept by software from beacon and reserved periods
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      fb_start_r <= '0;
      fb_end_r   <= '0;
      fb_en_r    <= 1'b0;
    end else begin
      if (wr_hit(pds_pkg::OFF_FB_START)) begin
        fb_start_r <= i_pwdata[pds_pkg::TIMER_W-1:0];
      end
      if (wr_hit(pds_pkg::OFF_FB_END)) begin
        fb_end_r <= i_pwdata[pds_pkg::TIMER_W-1:0];
      end
      if (wr_hit(pds_pkg::OFF_FB_CTRL)) begin
        fb_en_r <= i_pwdata[pds_pkg::FB_EN];
      end
    end
  end

  // Bytes pass untouched, so the two pad bits stay where the MAC put them
  pds_mem u_tx_mem (
    .i_clk   (i_clk),
    .i_we    (wr_hit(pds_pkg::OFF_TX_DATA) && state_r == TX_IDLE &&
              tx_wr_ptr_r < pds_pkg::BUF_LEN_MAX),
    .i_waddr (tx_wr_ptr_r[pds_pkg::BUF_AW-1:0]),
    .i_wdata (i_pwdata[7:0]),
    .i_raddr (tx_rd_ptr_r[pds_pkg::BUF_AW-1:0]),
    .o_rdata (tx_rdata)
  );

  //////////////////////////////////////////////////////////////////////////
  // Transmit sequencing

  assign go    = wr_hit(pds_pkg::OFF_TX_CMD) && i_pwdata[pds_pkg::CMD_GO];
  assign match = (timer_r == tx_req_r.start);
  assign busy  = i_carrier_busy | rx_active_r;
  assign last  = (tx_rd_ptr_r == tx_req_r.len - 1'b1);

  // Checks made when a request is taken; first failure found is reported
  always_comb begin
    chk_res = pds_pkg::RES_OK;
    if (tx_req_r.len == '0 || tx_req_r.len > pds_pkg::BUF_LEN_MAX) begin
      chk_res = pds_pkg::RES_BAD_LEN;
    end else if (!scheme_ok(tx_req_r.scheme)) begin
      chk_res = pds_pkg::RES_BAD_SCH;
    end else if (ahead(tx_req_r.start, timer_r) > pds_pkg::LATE_LIMIT) begin
      chk_res = pds_pkg::RES_LATE;
    end else if (fb_en_r && ahead(tx_req_r.start, fb_start_r) <=
                 ahead(fb_end_r, fb_start_r)) begin
      chk_res = pds_pkg::RES_FORBID;
    end
  end

  // Every way out of a request ends in exactly one confirmation
  always_comb begin
    fin     = 1'b0;
    fin_res = pds_pkg::RES_OK;
    case (state_r)
      TX_IDLE: begin
        fin     = go && (chk_res != pds_pkg::RES_OK);
        fin_res = chk_res;
      end
      TX_WAIT: begin
        fin     = match && busy;
        fin_res = pds_pkg::RES_BUSY;
      end
      TX_OUT:  fin = i_tx_ready && last;
      default: fin = 1'b0;
    endcase
  end

  // A go while not idle is ignored; the pending request is untouched
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_r     <= TX_IDLE;
      tx_rd_ptr_r <= '0;
    end else begin
      case (state_r)
        TX_IDLE: begin
          if (go && chk_res == pds_pkg::RES_OK) begin
            state_r <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          tx_rd_ptr_r <= '0;
          if (match) begin
            state_r <= busy ? TX_IDLE : TX_FETCH;
          end
        end
        TX_FETCH: state_r <= TX_LOAD;
        TX_LOAD:  state_r <= TX_OUT;
        TX_OUT: begin
          if (i_tx_ready) begin
            tx_rd_ptr_r <= tx_rd_ptr_r + 1'b1;
            state_r     <= last ? TX_IDLE : TX_FETCH;
          end
        end
        default: state_r <= TX_IDLE;
      endcase
    end
  end

  // Stream towards the modulator; level and scheme go out unchanged
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_tx_start <= 1'b0;
      o_tx_req   <= '0;
      o_tx_byte  <= '0;
      o_tx_valid <= 1'b0;
      o_tx_last  <= 1'b0;
    end else begin
      o_tx_start <= (state_r == TX_WAIT) && match && !busy;
      if (state_r == TX_WAIT && match) begin
        o_tx_req <= tx_req_r;
      end
      if (state_r == TX_LOAD) begin
        o_tx_byte  <= tx_rdata;
        o_tx_valid <= 1'b1;
        o_tx_last  <= last;
      end else if (state_r == TX_OUT && i_tx_ready) begin
        o_tx_valid <= 1'b0;
        o_tx_last  <= 1'b0;
      end
    end
  end

  // Confirmation flag: a new result beats a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      done_r <= 1'b0;
      res_r  <= pds_pkg::RES_OK;
    end else if (fin) begin
      done_r <= 1'b1;
      res_r  <= fin_res;
    end else if (wr_hit(pds_pkg::OFF_TX_STAT) &&
                 i_pwdata[pds_pkg::TXS_DONE]) begin
      done_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Receive path

  assign rx_set = rx_active_r && i_rx_frame_ok;
  assign rx_we  = rx_active_r && i_rx_byte_valid &&
                  rx_cnt_r < pds_pkg::BUF_LEN_MAX;

  // Frames arriving while an indication is unread are dropped whole
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rx_active_r <= 1'b0;
      rx_cnt_r    <= '0;
      rx_time_r   <= '0;
    end else if (i_rx_preamble && !rx_pend_r) begin
      rx_active_r <= 1'b1;
      rx_cnt_r    <= '0;
      rx_time_r   <= timer_r;
    end else if (rx_active_r) begin
      if (rx_we) begin
        rx_cnt_r <= rx_cnt_r + 1'b1;
      end
      if (i_rx_frame_ok || i_rx_frame_bad) begin
        rx_active_r <= 1'b0;
      end
    end
  end

  // Indication holds length, level and scheme; set beats software clear
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rx_pend_r   <= 1'b0;
      rx_len_r    <= '0;
      rx_info_r   <= '0;
      rx_rd_ptr_r <= '0;
    end else if (rx_set) begin
      rx_pend_r   <= 1'b1;
      rx_len_r    <= rx_cnt_r;
      rx_info_r   <= i_rx_info;
      rx_rd_ptr_r <= '0;
    end else begin
      if (wr_hit(pds_pkg::OFF_RX_STAT) && i_pwdata[pds_pkg::RXS_AVAIL]) begin
        rx_pend_r <= 1'b0;
      end
      if (acc && !i_pwrite && i_paddr == pds_pkg::OFF_RX_DATA) begin
        rx_rd_ptr_r <= rx_rd_ptr_r + 1'b1;
      end
    end
  end

  pds_mem u_rx_mem (
    .i_clk   (i_clk),
    .i_we    (rx_we),
    .i_waddr (rx_cnt_r[pds_pkg::BUF_AW-1:0]),
    .i_wdata (i_rx_byte),
    .i_raddr (rx_rd_ptr_r[pds_pkg::BUF_AW-1:0]),
    .o_rdata (rx_rdata)
  );

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence s_go_res(logic [pds_pkg::RES_W-1:0] r);
    state_r == TX_IDLE && go && chk_res == r;
  endsequence
  sequence s_conf(logic [pds_pkg::RES_W-1:0] r);
    done_r && res_r == r;
  endsequence

  a_tick_gap:
    assert property (tick |=> !tick [*8]) else $error("tick too soon");
  a_timer_step:
    assert property (tick |=> timer_r ==
      pds_pkg::TIMER_W'($past(timer_r) + 1'b1)) else $error("bad step");
  a_timer_hold:
    assert property (!tick |=> $stable(timer_r)) else $error("timer moved");
  a_timer_wrap:
    assert property (tick && timer_r == pds_pkg::TIMER_MAX |=> timer_r == '0)
    else $error("no wrap");
  a_start_match:
    assert property (o_tx_start |-> $past(timer_r) == o_tx_req.start)
    else $error("start off time");
  a_bad_scheme:
    assert property (s_go_res(pds_pkg::RES_BAD_SCH) |=>
      s_conf(pds_pkg::RES_BAD_SCH) ##0 state_r == TX_IDLE)
    else $error("scheme not refused");
  a_forbid_fail:
    assert property (s_go_res(pds_pkg::RES_FORBID) |=>
      s_conf(pds_pkg::RES_FORBID) ##1 !o_tx_start) else $error("forbid");
  a_busy_fail:
    assert property (state_r == TX_WAIT && match && busy |=>
      s_conf(pds_pkg::RES_BUSY) ##0 !o_tx_start) else $error("busy sent");
  a_tx_confirm:
    assert property (state_r == TX_OUT && i_tx_ready && last |=>
      s_conf(pds_pkg::RES_OK) ##0 !o_tx_valid) else $error("no confirm");
  a_one_pending:
    assert property (state_r != TX_IDLE |=> $stable(tx_req_r))
    else $error("pending request changed");
  a_rx_time:
    assert property (i_rx_preamble && !rx_pend_r |=>
      rx_time_r == $past(timer_r)) else $error("rx time");
  a_rx_valid:
    assert property ($rose(rx_pend_r) |-> $past(i_rx_frame_ok))
    else $error("indication without frame");
endmodule : pds_port

// *** pds_modem_model.sv ***
// Behavioural modem model: transmit byte sink and receive frame source
`timescale 1ns/10ps
module pds_modem_model (
  input  wire logic               i_clk,
  input  wire logic [7:0]         i_tx_byte,
  input  wire logic               i_tx_valid,
  output logic                    o_tx_ready,
  output logic                    o_rx_pre,
  output logic [7:0]              o_rx_byte,
  output logic                    o_rx_bval,
  output logic                    o_rx_ok,
  output logic                    o_rx_bad,
  output pds_pkg::pds_rx_info_type o_rx_info
);
  logic [7:0] got_q[$];
  initial begin
    o_tx_ready = 1'b0;
    o_rx_pre = 1'b0;
    o_rx_byte = 8'h00;
    o_rx_bval = 1'b0;
    o_rx_ok = 1'b0;
    o_rx_bad = 1'b0;
    o_rx_info = '0;
  end
  // Ready on alternate cycles, so the sender must hold each byte
  always @(posedge i_clk) begin
    if (i_tx_valid === 1'b1 && o_tx_ready)
      got_q.push_back(i_tx_byte);
    o_tx_ready <= ~o_tx_ready;
  end
  // One frame: preamble, byte pulses, good or bad end; lines inverted idle
  task automatic send(input logic [7:0] b[$],
                      input pds_pkg::pds_rx_info_type inf,
                      input logic good);
    @(posedge i_clk) o_rx_pre <= 1'b1;
    @(posedge i_clk) o_rx_pre <= 1'b0;
    foreach (b[i]) begin
      @(posedge i_clk) o_rx_byte <= b[i];
      o_rx_bval <= 1'b1;
      @(posedge i_clk) o_rx_bval <= 1'b0;
      o_rx_byte <= ~b[i];
    end
    @(posedge i_clk) o_rx_ok <= good;
    o_rx_bad <= !good;
    o_rx_info <= inf;
    @(posedge i_clk) o_rx_ok <= 1'b0;
    o_rx_bad <= 1'b0;
    o_rx_info <= ~inf;
  endtask : send
endmodule : pds_modem_model

// *** tb_phy_data_service_port.sv ***
// Self-checking bench for the PHY data service port
`timescale 1ns/10ps
module tb_phy_data_service_port;
  logic        i_clk = 1'b0;
  logic        i_srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        busy = 1'b0;
  logic [31:0] prdata, rd, t;
  logic        pready, pslverr, perr, tx_start, tx_valid, tx_ready;
  logic        pre, bval, fok, fbad, tx_last;
  logic [7:0]  last_byte;
  pds_pkg::pds_tx_req_type txreq;
  logic [7:0]  tx_byte, rbyte;
  pds_pkg::pds_rx_info_type rinfo;
  int          err_count = 0;
  int          n_compared = 0;
  int          starts = 0;
  // Failing requests: length, scheme/level, start offset, expected code
  logic [15:0] lens[7] = '{16'h0, 16'h0801, 1, 1, 1, 1, 1};
  logic [7:0]  prms[7] = '{0, 0, 8'h30, 8'h70, 0, 0, 0};
  logic [19:0] offs[7] = '{2, 2, 2, 2, 20'hfffff, 2, 1};
  logic [7:0]  codes[7] = '{2, 2, 3, 3, 1, 7, 6};
  // Bytes of the received frame, in arrival order
  logic [7:0]  rxb[3] = '{8'hc2, 8'h11, 8'h7e};

  always #2 i_clk = ~i_clk;
  always @(posedge i_clk) if (tx_start === 1'b1) starts <= starts + 1;
  // Byte that the modem took together with the end-of-frame mark
  always @(posedge i_clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1 && tx_last === 1'b1) begin
      last_byte <= tx_byte;
    end
  end

  pds_port dut (.i_clk(i_clk), .i_srst(i_srst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_tx_start(tx_start), .o_tx_req(txreq),
    .o_tx_byte(tx_byte), .o_tx_valid(tx_valid), .o_tx_last(tx_last),
    .i_tx_ready(tx_ready), .i_carrier_busy(busy), .i_rx_preamble(pre),
    .i_rx_byte(rbyte), .i_rx_byte_valid(bval), .i_rx_frame_ok(fok),
    .i_rx_frame_bad(fbad), .i_rx_info(rinfo));
  pds_modem_model modem (.i_clk(i_clk), .i_tx_byte(tx_byte),
    .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .o_rx_pre(pre),
    .o_rx_byte(rbyte), .o_rx_bval(bval), .o_rx_ok(fok), .o_rx_bad(fbad),
    .o_rx_info(rinfo));

  // One APB transfer; the wait on pready is cut only by the watchdog
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input string s, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  // Load a request with up to 4 bytes c1, c2, ... then issue go
  task automatic req(input logic [15:0] len, input logic [7:0] prm,
                     input logic [19:0] st);
    apb(1'b1, pds_pkg::OFF_TX_LEN, {16'h0, len});
    for (int i = 0; i < len && i < 4; i++)
      apb(1'b1, pds_pkg::OFF_TX_DATA, 32'(8'hc1 + i));
    apb(1'b1, pds_pkg::OFF_TX_PARAM, {24'h0, prm});
    apb(1'b1, pds_pkg::OFF_TX_TIME, {12'h0, st});
    apb(1'b1, pds_pkg::OFF_TX_CMD, 32'h1);
  endtask : req

  task automatic wait_done();
    do apb(1'b0, pds_pkg::OFF_TX_STAT, 32'h0); while (rd[1] !== 1'b1);
  endtask : wait_done

  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // Watchdog: the whole sequence needs well under 20000 cycles
  initial begin
    repeat (60000) @(posedge i_clk);
    err_count++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b0;
    apb(1'b0, pds_pkg::OFF_TIMER, 32'h0);
    chk("timer at reset", 32'h0, rd);
    t = rd;
    repeat (2500) @(posedge i_clk);
    apb(1'b0, pds_pkg::OFF_TIMER, 32'h0);
    chk("timer one tick", t + 1, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", 32'h1, perr);
    apb(1'b0, pds_pkg::OFF_TX_DATA, 32'h0);
    chk("write-only read", 32'h0, rd);
    // Good frame, second go while pending must be ignored
    apb(1'b0, pds_pkg::OFF_TIMER, 32'h0);
    t = rd;
    req(16'h2, 8'h47, t[19:0] + 20'h2);
    apb(1'b1, pds_pkg::OFF_TX_CMD, 32'h1);
    wait_done();
    chk("tx result", 32'h0, rd[15:8]);
    chk("tx starts", 32'h1, starts);
    chk("tx bytes", 32'hc1c2, {modem.got_q[0], modem.got_q[1]});
    chk("tx last byte", 32'hc2, last_byte);
    chk("req length", 32'h2, txreq.len);
    chk("req level", 32'h7, txreq.level);
    chk("req scheme", 32'h4, txreq.scheme);
    chk("req time", 32'(t[19:0] + 20'h2), txreq.start);
    apb(1'b0, pds_pkg::OFF_TIMER, 32'h0);
    chk("start instant", t + 2, rd);
    apb(1'b1, pds_pkg::OFF_TX_STAT, 32'h2);
    apb(1'b1, pds_pkg::OFF_FB_START, 32'h0);
    apb(1'b1, pds_pkg::OFF_FB_END, 32'hfffff);
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, pds_pkg::OFF_TIMER, 32'h0);
      t = rd;
      apb(1'b1, pds_pkg::OFF_FB_CTRL, {31'h0, i == 5});
      busy <= (i == 6);
      req(lens[i], prms[i], t[19:0] + offs[i]);
      wait_done();
      chk("fail code", codes[i], rd[15:8]);
      chk("nothing sent", 32'h1, starts);
      apb(1'b1, pds_pkg::OFF_TX_STAT, 32'h2);
    end
    busy <= 1'b0;
    // A frame that ends bad leaves no indication
    modem.send('{8'h55}, 7'h00, 1'b0);
    apb(1'b0, pds_pkg::OFF_RX_STAT, 32'h0);
    chk("bad frame dropped", 32'h0, rd[0]);
    // Receive one valid frame
    apb(1'b0, pds_pkg::OFF_TIMER, 32'h0);
    t = rd;
    modem.send('{8'hc2, 8'h11, 8'h7e}, 7'h4d, 1'b1);
    apb(1'b0, pds_pkg::OFF_RX_STAT, 32'h0);
    chk("rx status", 32'h00030591, rd);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, pds_pkg::OFF_RX_DATA, 32'h0);
      chk("rx byte", rxb[i], rd);
    end
    apb(1'b0, pds_pkg::OFF_RX_TIME, 32'h0);
    chk("rx time", 32'h1, 32'((rd - t) <= 1));
    apb(1'b1, pds_pkg::OFF_RX_STAT, 32'h1);
    apb(1'b0, pds_pkg::OFF_RX_STAT, 32'h0);
    chk("avail cleared", 32'h0, rd[0]);
    give_verdict();
  end
endmodule : tb_phy_data_service_port
